// >>> logic/bsfs_pkg.sv
// Shared constants and types for the buck start-up and fault sequencer
package bsfs_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLANK_NS      = 160;
  localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_CYCLES = 4096;
  // Pre-bias pulse groups and low-side duty steps (quarters)
  localparam int GRP1_PULSES   = 32;
  localparam int GRP2_PULSES   = 16;
  localparam int GRP3_PULSES   = 8;
  localparam logic [2:0] STEP_FIRST = 3'h1;
  localparam logic [2:0] STEP_LAST  = 3'h3;
  localparam logic [2:0] STEP_FULL  = 3'h4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_HICCUP   = 8'h10;
  // Field positions and reset values
  localparam int CTRL_RUN_BIT    = 0;
  localparam logic CTRL_RUN_RST  = 1'b1;
  localparam int ST_POR_BIT      = 0;
  localparam int ST_OC_BIT       = 1;
  localparam int ST_OT_BIT       = 2;
  localparam int ST_SD_BIT       = 3;
  localparam int ST_STEP_LSB     = 4;
  localparam int ST_STATE_LSB    = 8;
  localparam int EV_OC           = 0;
  localparam int EV_OT           = 1;
  localparam int EV_SD           = 2;
  localparam int EV_LOCK         = 3;
  localparam int EV_W            = 4;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Comparator and modulator inputs, all asynchronous to the core clock
  typedef struct packed {
    logic osc;       // Switching oscillator, one rising edge per cycle
    logic hs_pwm;    // High-side demand from the modulator
    logic ot_hot;    // Over-temperature comparator, hysteresis is analog
    logic oc_below;  // current_limit_sense below ground
    logic ss_low;    // soft_start_node below shutdown level
    logic en_ok;     // Enable above its stop threshold
    logic vcc_ok;    // Bias supply out of supply_lockout
  } bsfs_comp_t;

  // Gate driver outputs
  typedef struct packed {
    logic hs_gate;
    logic hs_oe;
    logic ls_gate;
    logic ls_oe;
  } bsfs_drv_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT_HS, ST_STEP, ST_RUN, ST_HICCUP, ST_THERMAL
  } bsfs_state_t;
endpackage : bsfs_pkg

// >>> logic/bsfs_sequencer.sv
// Start-up, pre-bias and fault sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
// Operation
// - Both gates off while bias supply or enable is below lockout.
// - Power-on-ready only when supply and enable are both valid together.
// - Power-on-ready releases the soft-start node to start soft-start.
// - Enable below stop threshold puts both drivers in high impedance.
// - External soft-start pull-down stops switching until the node is cycled.
// - Low-side stays off until the first high-side pulse after start.
// - Low-side duty then rises by quarters up to full value.
// - Pre-bias groups last thirty-two, sixteen and eight pulses.
// - Over-current detection stays active during soft-start.
// - Over-current is sense below ground while low-side conducts.
// - Over-current latches the trip flag and enters hiccup.
// - Hiccup discharges soft-start and counts 4096 switching cycles.
// - Hiccup end clears the flag and retries start-up.
// - Current sampling blanked about 160 ns after low-side rises.
// - Over-temperature turns both switches off and discharges soft-start.
// - Restart automatically once temperature comparator releases.
module bsfs_sequencer #(
  parameter int ADDR_W        = 8,
  parameter int PER_W         = 12,
  parameter int HICCUP_CYCLES = bsfs_pkg::HICCUP_CYCLES
) (
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 RST_I,
  input  wire bsfs_pkg::bsfs_comp_t COMP_I,
  output      bsfs_pkg::bsfs_drv_t  DRV_O,
  output      logic                 SS_DISCHARGE_O,
  output      logic                 POWER_ON_READY_O,
  output      logic                 OVERCURRENT_TRIP_O,
  output      logic                 IRQ_O,
  input  wire logic [ADDR_W-1:0]    AWADDR_I,
  input  wire logic                 AWVALID_I,
  output      logic                 AWREADY_O,
  input  wire logic [31:0]          WDATA_I,
  input  wire logic [3:0]           WSTRB_I,
  input  wire logic                 WVALID_I,
  output      logic                 WREADY_O,
  output      logic [1:0]           BRESP_O,
  output      logic                 BVALID_O,
  input  wire logic                 BREADY_I,
  input  wire logic [ADDR_W-1:0]    ARADDR_I,
  input  wire logic                 ARVALID_I,
  output      logic                 ARREADY_O,
  output      logic [31:0]          RDATA_O,
  output      logic [1:0]           RRESP_O,
  output      logic                 RVALID_O,
  input  wire logic                 RREADY_I
);
  import bsfs_pkg::*;

  localparam int HW = $clog2(HICCUP_CYCLES + 1);
  localparam int CW = 7;
  localparam logic [HW-1:0] HIC_LAST = HW'(HICCUP_CYCLES - 1);
  localparam logic [4:0] BLANK_DONE = 5'(BLANK_CYC);

  logic [CW-1:0] sync1, sync2, sync3, cmp_bits;
  bsfs_comp_t    cmp, cmp_d;
  bsfs_state_t   state, next_state;
  bsfs_drv_t     next_drv;
  logic          por, ctrl_run, oc_trip, ext_sd, next_ext_sd, ss_armed;
  logic          osc_tick, hs_rise, oc_valid, run_ok, next_discharge;
  logic [2:0]    step;
  logic [5:0]    pulse_cnt, step_len;
  logic [HW-1:0] hic_cnt;
  logic [4:0]    blank_cnt;
  logic [PER_W-1:0] per_cnt, last_per, ls_ph;
  logic          ls_window;
  logic [EV_W-1:0] irq_stat, irq_mask, ev;
  logic          aw_full, w_full, wr_fire, rd_fire;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic [31:0]   rd_val;
  logic          rd_hit;

  // Three-stage synchroniser; a bit changes once stages two and three agree
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      cmp_bits <= '0;
    end else begin
      sync1 <= COMP_I;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < CW; i++) begin
        if (sync2[i] == sync3[i]) begin
          cmp_bits[i] <= sync3[i];
        end
      end
    end
  end
  assign cmp = cmp_bits;

  // Delayed copy for edge detection on the clean values
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmp_d <= '0;
    end else begin
      cmp_d <= cmp;
    end
  end
  assign osc_tick = cmp.osc && !cmp_d.osc;
  assign hs_rise  = cmp.hs_pwm && !cmp_d.hs_pwm;

  // Power-on-ready needs both qualifications in the same cycle
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      por <= 1'b0;
    end else begin
      por <= cmp.vcc_ok && cmp.en_ok;
    end
  end
  assign run_ok = por && ctrl_run;

  // Soft-start pulled low from outside: arm only once the node was seen high
  // after our own discharge, so our release ramp is not mistaken for a pull.
  always_comb begin
    next_ext_sd = ext_sd;
    if (!por || !cmp.ss_low) begin
      next_ext_sd = 1'b0;
    end else if (ss_armed && !SS_DISCHARGE_O) begin
      next_ext_sd = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_sd   <= 1'b0;
      ss_armed <= 1'b0;
    end else begin
      ext_sd <= next_ext_sd;
      if (SS_DISCHARGE_O || !por) begin
        ss_armed <= 1'b0;
      end else if (!cmp.ss_low) begin
        ss_armed <= 1'b1;
      end
    end
  end

  // Group length of the current pre-bias step
  always_comb begin
    unique case (step)
      3'h1:    step_len = 6'(GRP1_PULSES);
      3'h2:    step_len = 6'(GRP2_PULSES);
      default: step_len = 6'(GRP3_PULSES);
    endcase
  end

  // Over-current is valid only after blanking while the low side conducts
  assign oc_valid = (state == ST_STEP || state == ST_RUN) && DRV_O.ls_gate
                  && blank_cnt == BLANK_DONE && cmp.oc_below;

  // Sequencer; lockout or a cleared run bit beats thermal, thermal beats everything else
  always_comb begin
    next_state = state;
    if (!run_ok) begin
      next_state = ST_OFF;
    end else if (cmp.ot_hot) begin
      next_state = ST_THERMAL;
    end else if (ext_sd) begin
      next_state = ST_WAIT_HS;
    end else begin
      unique case (state)
        ST_OFF:     next_state = ST_WAIT_HS;
        ST_THERMAL: next_state = ST_WAIT_HS;
        ST_WAIT_HS: if (hs_rise) next_state = ST_STEP;
        ST_STEP: begin
          if (oc_valid) begin
            next_state = ST_HICCUP;
          end else if (hs_rise && pulse_cnt == step_len - 6'h1 && step == STEP_LAST) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN:     if (oc_valid) next_state = ST_HICCUP;
        ST_HICCUP:  if (osc_tick && hic_cnt == HIC_LAST) next_state = ST_WAIT_HS;
        default:    next_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Pre-bias step and pulse count
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      step      <= STEP_FIRST;
      pulse_cnt <= '0;
    end else if (next_state == ST_RUN) begin
      step      <= STEP_FULL;
      pulse_cnt <= '0;
    end else if (next_state != ST_STEP) begin
      step      <= STEP_FIRST;
      pulse_cnt <= '0;
    end else if (state == ST_STEP && hs_rise) begin
      if (pulse_cnt == step_len - 6'h1) begin
        step      <= step + 3'h1;
        pulse_cnt <= '0;
      end else begin
        pulse_cnt <= pulse_cnt + 6'h1;
      end
    end
  end

  // Period measure and time since high side fell, for the quarter window
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      per_cnt  <= '0;
      last_per <= '0;
      ls_ph    <= '0;
    end else begin
      if (osc_tick) begin
        last_per <= per_cnt;
        per_cnt  <= '0;
      end else if (per_cnt != '1) begin
        per_cnt <= per_cnt + 1'b1;
      end
      if (cmp.hs_pwm) begin
        ls_ph <= '0;
      end else if (ls_ph != '1) begin
        ls_ph <= ls_ph + 1'b1;
      end
    end
  end
  // Low side on for step quarters of a period; saturating counts keep it safe
  assign ls_window = (16'({ls_ph, 2'h0}) < 16'(last_per) * 16'(step));

  // Gate and discharge decisions, registered so outputs come from flops
  always_comb begin
    next_drv.hs_oe   = cmp.en_ok;
    next_drv.ls_oe   = cmp.en_ok;
    next_drv.hs_gate = 1'b0;
    next_drv.ls_gate = 1'b0;
    next_discharge   = (next_state == ST_OFF || next_state == ST_HICCUP
                     || next_state == ST_THERMAL);
    if (cmp.vcc_ok && cmp.en_ok && !next_ext_sd && !cmp.ot_hot) begin
      unique case (next_state)
        ST_WAIT_HS: next_drv.hs_gate = cmp.hs_pwm;
        ST_STEP: begin
          next_drv.hs_gate = cmp.hs_pwm;
          next_drv.ls_gate = !cmp.hs_pwm && ls_window;
        end
        ST_RUN: begin
          next_drv.hs_gate = cmp.hs_pwm;
          next_drv.ls_gate = !cmp.hs_pwm;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DRV_O          <= '0;
      SS_DISCHARGE_O <= 1'b1;
    end else begin
      DRV_O          <= next_drv;
      SS_DISCHARGE_O <= next_discharge;
    end
  end

  // Blanking counter restarts at every low-side rise
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      blank_cnt <= '0;
    end else if (!DRV_O.ls_gate) begin
      blank_cnt <= '0;
    end else if (blank_cnt != BLANK_DONE) begin
      blank_cnt <= blank_cnt + 5'h1;
    end
  end

  // Trip flag and hiccup counter, the counter in switching cycles
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      oc_trip <= 1'b0;
      hic_cnt <= '0;
    end else begin
      if (!por) begin
        oc_trip <= 1'b0;
      end else if (oc_valid && next_state == ST_HICCUP) begin
        oc_trip <= 1'b1;
      end else if (state == ST_HICCUP && next_state != ST_HICCUP) begin
        oc_trip <= 1'b0;
      end
      if (state != ST_HICCUP || !por) begin
        hic_cnt <= '0;
      end else if (osc_tick) begin
        hic_cnt <= hic_cnt + 1'b1;
      end
    end
  end
  assign POWER_ON_READY_O   = por;
  assign OVERCURRENT_TRIP_O = oc_trip;

  // Interrupt events
  assign ev[EV_OC]   = oc_valid && next_state == ST_HICCUP;
  assign ev[EV_OT]   = next_state == ST_THERMAL && state != ST_THERMAL;
  assign ev[EV_SD]   = next_ext_sd && !ext_sd;
  assign ev[EV_LOCK] = por && !(cmp.vcc_ok && cmp.en_ok);

  // Write channel: address and data taken independently, response follows both
  assign AWREADY_O = !aw_full;
  assign WREADY_O  = !w_full;
  assign wr_fire   = aw_full && w_full && !BVALID_O;
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_full  <= 1'b0;
      w_full   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= '0;
      w_strb   <= '0;
      BVALID_O <= 1'b0;
      BRESP_O  <= RESP_OKAY;
    end else begin
      if (AWVALID_I && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && !w_full) begin
        w_full <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      if (wr_fire) begin
        aw_full  <= 1'b0;
        w_full   <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O  <= (8'(aw_addr) == OFS_CTRL || 8'(aw_addr) == OFS_IRQ_MASK)
                  ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  // Writable registers; only the low byte carries bits
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_run <= CTRL_RUN_RST;
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_fire && w_strb[0]) begin
      if (8'(aw_addr) == OFS_CTRL) ctrl_run <= w_data[CTRL_RUN_BIT];
      if (8'(aw_addr) == OFS_IRQ_MASK) irq_mask <= w_data[EV_W-1:0];
    end
  end

  // Read mux
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case (8'(ARADDR_I))
      OFS_CTRL:     rd_val[CTRL_RUN_BIT] = ctrl_run;
      OFS_STATUS: begin
        rd_val[ST_POR_BIT] = por;
        rd_val[ST_OC_BIT]  = oc_trip;
        rd_val[ST_OT_BIT]  = cmp.ot_hot;
        rd_val[ST_SD_BIT]  = ext_sd;
        rd_val[ST_STEP_LSB +: 3]  = step;
        rd_val[ST_STATE_LSB +: 3] = 3'(state);
      end
      OFS_IRQ_STAT: rd_val[EV_W-1:0] = irq_stat;
      OFS_IRQ_MASK: rd_val[EV_W-1:0] = irq_mask;
      OFS_HICCUP:   rd_val[HW-1:0] = hic_cnt;
      default:      rd_hit = 1'b0;
    endcase
  end

  assign ARREADY_O = !RVALID_O;
  assign rd_fire   = ARVALID_I && !RVALID_O;
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O  <= '0;
      RRESP_O  <= RESP_OKAY;
    end else if (rd_fire) begin
      RVALID_O <= 1'b1;
      RDATA_O  <= rd_val;
      RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end

  // Sticky status cleared by reading it; a new event in that cycle survives
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat <= '0;
    end else if (rd_fire && 8'(ARADDR_I) == OFS_IRQ_STAT) begin
      irq_stat <= ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end
  assign IRQ_O = |(irq_stat & irq_mask);

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_lockout_gates_off: assert property (
    !(cmp.vcc_ok && cmp.en_ok) |=> !DRV_O.hs_gate && !DRV_O.ls_gate)
    else $error("Gate driven during lockout");
  a_por_both_valid: assert property (
    $rose(por) |-> $past(cmp.vcc_ok) && $past(cmp.en_ok))
    else $error("Power-on-ready without both qualifications");
  a_ss_release: assert property (
    $rose(por) && ctrl_run && !cmp.ot_hot |=> !SS_DISCHARGE_O)
    else $error("Soft-start not released after power-on-ready");
  a_enable_hiz: assert property (
    !cmp.en_ok |=> !DRV_O.hs_oe && !DRV_O.ls_oe && !DRV_O.hs_gate)
    else $error("Drivers not high impedance with enable low");
  a_ext_shutdown: assert property (
    ext_sd |-> !DRV_O.hs_gate && !DRV_O.ls_gate)
    else $error("Switching during external shutdown");
  a_no_ls_first: assert property (
    state == ST_WAIT_HS |-> !DRV_O.ls_gate)
    else $error("Low side on before first high-side pulse");
  a_step_group: assert property (
    state == ST_STEP && $changed(step) |->
      $past(pulse_cnt) == $past(step_len) - 6'h1 && $past(hs_rise))
    else $error("Pre-bias step left before its pulse group ended");
  a_blank_sample: assert property (
    oc_valid |-> DRV_O.ls_gate && blank_cnt == BLANK_DONE && $past(DRV_O.ls_gate, 15))
    else $error("Current sampled inside blanking time");
  a_oc_hiccup: assert property (
    oc_valid && run_ok && !cmp.ot_hot && !ext_sd |=> oc_trip && state == ST_HICCUP
      ##1 SS_DISCHARGE_O)
    else $error("Over-current did not latch and enter hiccup");
  a_hiccup_hold: assert property (
    state == ST_HICCUP |-> SS_DISCHARGE_O && hic_cnt <= HIC_LAST)
    else $error("Soft-start released during hiccup count");
  a_hiccup_end: assert property (
    state == ST_HICCUP && osc_tick && hic_cnt == HIC_LAST && run_ok && !cmp.ot_hot
      && !ext_sd |=> !oc_trip && state == ST_WAIT_HS)
    else $error("Hiccup completion did not retry start-up");
  a_thermal_off: assert property (
    cmp.ot_hot |=> !DRV_O.hs_gate && !DRV_O.ls_gate && SS_DISCHARGE_O)
    else $error("Over-temperature did not stop switching");
  a_por_clears: assert property (
    !por |=> !oc_trip && hic_cnt == '0 && step == STEP_FIRST)
    else $error("Loss of power-on-ready left state set");
endmodule : bsfs_sequencer

// >>> tb/bsfs_analog_model.sv
// Far-side model: oscillator, modulator demand, comparators and soft-start node
`timescale 1ns/1ps
module bsfs_analog_model
  import bsfs_pkg::*;
#(
  parameter int PER = 40
) (
  input  wire logic       clk_i,
  input  wire bsfs_drv_t  drv_i,
  input  wire logic       ss_discharge_i,
  input  wire logic [4:0] ctl_i,  // {vcc, en, hot, overload, pull}
  output      bsfs_comp_t comp_o
);
  int ph   = 0;
  int ss_v = 0;

  // Node charges slowly, so a released pin stays low for a while
  always @(posedge clk_i) begin
    ph   <= (ph + 1) % PER;
    ss_v <= (ss_discharge_i || ctl_i[0]) ? 0 : (ss_v < 20 ? ss_v + 1 : ss_v);
  end

  // Sense node only dips below ground while the low-side switch conducts
  assign comp_o.osc      = ph < PER / 2;
  assign comp_o.hs_pwm   = ph < PER / 4;
  assign comp_o.ot_hot   = ctl_i[2];
  assign comp_o.oc_below = ctl_i[1] && drv_i.ls_gate;
  assign comp_o.ss_low   = ss_v < 10;
  assign comp_o.en_ok    = ctl_i[3];
  assign comp_o.vcc_ok   = ctl_i[4];
endmodule : bsfs_analog_model

// >>> tb/bsfs_sequencer_tb.sv
// Self-checking bench for the start-up and fault sequencer
`timescale 1ns/1ps
module bsfs_sequencer_tb;
  import bsfs_pkg::*;
  localparam int PER = 40;
  localparam int HC  = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  ctl = 5'h08;
  bsfs_comp_t  comp;
  bsfs_drv_t   drv;
  logic        ss_dis, por, trip, irq;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rdat, m;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  int          mismatches = 0, check_count = 0, cyc, ls_early = 0, seed;
  logic        seen_hs = 1'b0;
  int          q[$];

  always #5 clk = ~clk;

  bsfs_analog_model #(.PER(PER)) far (.clk_i(clk), .drv_i(drv), .ss_discharge_i(ss_dis),
    .ctl_i(ctl), .comp_o(comp));

  bsfs_sequencer #(.HICCUP_CYCLES(HC)) dut (.CORE_CLK_I(clk), .RST_I(rst), .COMP_I(comp),
    .DRV_O(drv), .SS_DISCHARGE_O(ss_dis), .POWER_ON_READY_O(por), .OVERCURRENT_TRIP_O(trip),
    .IRQ_O(irq), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(4'hf), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));

  // Low-side must not conduct before the first high-side pulse of each start
  always @(negedge clk) begin
    if (ss_dis) seen_hs = 1'b0;
    else if (drv.hs_gate) seen_hs = 1'b1;
    else if (drv.ls_gate && !seen_hs) ls_early++;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Accepts a count within tol of the expected figure
  task automatic chk_near(input string nm, input int e, input int g, input int tol);
    chk(nm, e, (g >= e - tol && g <= e + tol) ? e : g);
  endtask : chk_near

  task automatic give_up(input string nm);
    chk(nm, 32'h0, 32'h1);
    print_verdict();
  endtask : give_up

  function automatic logic sig(input int w);
    case (w)
      0: return trip;
      1: return ss_dis;
      2: return drv.hs_gate;
      default: return por;
    endcase
  endfunction : sig

  task automatic wait_lvl(input int w, input logic v, input int lim);
    cyc = 0;
    while (sig(w) !== v) begin
      @(negedge clk);
      cyc++;
      if (cyc > lim) give_up("wait_timeout");
    end
  endtask : wait_lvl

  task automatic set(input int i, input logic v);
    @(posedge clk);
    ctl[i] <= v;
  endtask : set

  // Ready is sampled at the falling edge; signals drop after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int  n = 0;
    logic ta, tw, tb;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 50) give_up("write_timeout");
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      if (tb) rsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int  n = 0;
    logic ta, tr;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      if (++n > 50) give_up("read_timeout");
      ta = arvalid && arready;
      tr = rready && rvalid;
      if (tr) rdat = rdata;
      if (tr) rsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask : rd

  initial begin
    logic [2:0] last;
    int         cnt;
    seed = 32'h068b5ba6;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk("drv_reset", 32'h0, 32'(drv));
    rd(OFS_CTRL);
    chk("ctrl_reset", 32'(CTRL_RUN_RST), 32'(rdat[CTRL_RUN_BIT]));
    rd(OFS_IRQ_MASK);
    chk("mask_reset", 32'(IRQ_MASK_RST), rdat);
    rd(8'h14);
    chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(rsp));
    chk("unmapped_rdata", 32'h0, rdat);
    wr(8'h20, 32'hffffffff);
    chk("unmapped_bresp", 32'(RESP_SLVERR), 32'(rsp));
    m = ($random(seed) & 32'hf) | 32'h1;
    wr(OFS_IRQ_MASK, m);
    rd(OFS_IRQ_MASK);
    chk("mask_rw", m, rdat);
    chk("por_no_vcc", 32'h0, 32'(por));
    chk("gates_lockout", 32'h0, 32'({drv.hs_gate, drv.ls_gate}));
    set(4, 1'b1);
    wait_lvl(3, 1'b1, 20);
    wait_lvl(1, 1'b0, 20);
    // Pre-bias groups, polled once per switching period
    q = {GRP1_PULSES, GRP2_PULSES, GRP3_PULSES};
    last = STEP_FIRST;
    cnt = 0;
    for (int i = 0; i < 80; i++) begin
      wait_lvl(2, 1'b1, 2 * PER);
      rd(OFS_STATUS);
      if (rdat[ST_STATE_LSB +: 3] == 3'(ST_RUN)) break;
      if (rdat[ST_STEP_LSB +: 3] != last) begin
        chk("step_order", 32'(last + 3'h1), 32'(rdat[ST_STEP_LSB +: 3]));
        chk_near("group_len", q.pop_front(), cnt, 1);
        cnt = 0;
        last = rdat[ST_STEP_LSB +: 3];
      end
      cnt++;
      wait_lvl(2, 1'b0, PER);
    end
    chk_near("group_len", q.pop_front(), cnt, 1);
    chk("last_step", 32'(STEP_LAST), 32'(last));
    // Overload in steady run, then left on across the retry
    set(1, 1'b1);
    wait_lvl(0, 1'b1, 4 * PER);
    chk("oc_discharge", 32'h1, 32'(ss_dis));
    chk("oc_gates", 32'h0, 32'({drv.hs_gate, drv.ls_gate}));
    chk("oc_irq", 32'h1, 32'(irq));
    // Counter has seen at most one switching cycle this early in the hiccup
    rd(OFS_HICCUP);
    chk_near("hiccup_cnt", 0, int'(rdat), 1);
    wait_lvl(0, 1'b0, HC * PER + 20);
    chk_near("hiccup_len", HC * PER - PER / 2, cyc, PER / 2 + 6);
    chk("retry_release", 32'h0, 32'(ss_dis));
    wait_lvl(0, 1'b1, 60 * PER);
    rd(OFS_IRQ_STAT);
    chk("stat_oc", 32'h1, 32'(rdat[EV_OC]));
    @(negedge clk);
    chk("irq_cleared", 32'h0, 32'(irq));
    set(1, 1'b0);
    wait_lvl(0, 1'b0, HC * PER + 20);
    // Over-temperature trip and automatic restart
    wait_lvl(2, 1'b1, 70 * PER);
    set(2, 1'b1);
    wait_lvl(1, 1'b1, 20);
    chk("ot_gates", 32'h0, 32'({drv.hs_gate, drv.ls_gate}));
    rd(OFS_IRQ_STAT);
    chk("stat_ot", 32'h1, 32'(rdat[EV_OT]));
    set(2, 1'b0);
    wait_lvl(1, 1'b0, 20);
    wait_lvl(2, 1'b1, 4 * PER);
    // External pull on the soft-start node
    set(0, 1'b1);
    wait_lvl(2, 1'b0, PER);
    cnt = 0;
    repeat (3 * PER) begin
      @(negedge clk);
      cnt += int'(drv.hs_gate);
    end
    chk("sd_quiet", 32'h0, 32'(cnt));
    rd(OFS_IRQ_STAT);
    chk("stat_sd", 32'h1, 32'(rdat[EV_SD]));
    set(0, 1'b0);
    wait_lvl(2, 1'b1, 6 * PER);
    // Run bit cleared by software: discharge and gates off, supplies still qualified
    wr(OFS_CTRL, 32'h0);
    wait_lvl(1, 1'b1, 20);
    chk("ctrl_off_gates", 32'h0, 32'({drv.hs_gate, drv.ls_gate}));
    chk("ctrl_off_por", 32'h1, 32'(por));
    wr(OFS_CTRL, 32'h1 << CTRL_RUN_BIT);
    wait_lvl(1, 1'b0, 20);
    wait_lvl(2, 1'b1, 4 * PER);
    // Enable below stop threshold
    set(3, 1'b0);
    wait_lvl(3, 1'b0, 20);
    repeat (2) @(negedge clk);
    chk("hi_z", 32'h0, 32'({drv.hs_oe, drv.ls_oe}));
    chk("trip_idle", 32'h0, 32'(trip));
    rd(OFS_IRQ_STAT);
    chk("stat_lock", 32'h1, 32'(rdat[EV_LOCK]));
    chk("ls_first", 32'h0, 32'(ls_early));
    print_verdict();
  end
endmodule : bsfs_sequencer_tb
